// File: rtl/ac_link_host.sv
// ac-link host controller with axi4-lite register port
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "ac_link_consts.svh"
module ac_link_host
    import ac_link_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // link pins
    input wire logic link_bit_clk,
    input wire logic link_sdata_in,
    output logic link_sync,
    output logic link_sdata_out,
    output logic link_reset_n
);
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic [19:0] slot_of(input logic [255:0] f, input int n);
        return f[239 - 20 * (n - 1) -: 20];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [1:0] pins_s;
    logic bclk_q;
    link_state_e state, next_state;
    logic hold_busy;
    logic [7:0] frame_cnt;
    logic frames_live;
    logic [255:0] tx_shift;
    logic [254:0] rx_shift;
    logic run;
    cmd_s cmd;
    pcm_s play, rec;
    logic [19:0] slot12;
    logic cmd_pend, rd_wait, play_pend;
    logic codec_ready, ready_q;
    logic rd_done;
    logic [6:0] rd_idx;
    logic [15:0] rd_data;
    logic aw_got, w_got;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] rd_mux;
    logic rd_hit, wr_hit;

    ////////////////////////////////////////////////////////////////////////
    // pin capture and bit clock edges
    bit_sync #(.WIDTH(2)) u_pin_sync (
        .clk(aclk),
        .rst_n(aresetn),
        .ce(ce),
        .d({link_bit_clk, link_sdata_in}),
        .q(pins_s)
    );
    wire bclk_s = pins_s[1];
    wire din_s = pins_s[0];
    wire bclk_rise = ce & bclk_s & ~bclk_q;
    wire bclk_fall = ce & ~bclk_s & bclk_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) bclk_q <= 1'b0;
        else if (ce) bclk_q <= bclk_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire aw_hs = awvalid & awready;
    wire w_hs = wvalid & wready;
    wire ar_hs = arvalid & arready;
    wire do_wr = aw_got & w_got & ~bvalid;
    wire wr_ctrl = do_wr & (aw_addr_q == `REG_CTRL);
    wire wr_cmd = do_wr & (aw_addr_q == `REG_CMD);
    wire wr_pl = do_wr & (aw_addr_q == `REG_PLAY_L);
    wire wr_pr = do_wr & (aw_addr_q == `REG_PLAY_R);
    wire [31:0] ctrl_new = merge({31'h0000_0000, run}, w_data_q, w_strb_q);
    wire [31:0] cmd_new = merge({8'h00, cmd}, w_data_q, w_strb_q);
    wire [31:0] pl_new = merge({12'h000, play.left}, w_data_q, w_strb_q);
    wire [31:0] pr_new = merge({12'h000, play.right}, w_data_q, w_strb_q);
    wire cold_go = wr_ctrl & ctrl_new[`CTRL_COLD];
    wire warm_go = wr_ctrl & ctrl_new[`CTRL_WARM];
    wire rd_clr = ar_hs & (araddr == `REG_RDATA);
    always_comb begin
        wr_hit = 1'b1;
        if (aw_addr_q == `REG_CTRL) wr_hit = 1'b1;
        else if (aw_addr_q == `REG_CMD) wr_hit = 1'b1;
        else if (aw_addr_q == `REG_PLAY_L) wr_hit = 1'b1;
        else if (aw_addr_q == `REG_PLAY_R) wr_hit = 1'b1;
        else wr_hit = 1'b0;
    end
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (araddr == `REG_CTRL) rd_mux = {31'h0000_0000, run};
        else if (araddr == `REG_STAT)
            rd_mux = {26'h000_0000, state, play_pend, rd_done, cmd_pend, codec_ready};
        else if (araddr == `REG_CMD) rd_mux = {8'h00, cmd};
        else if (araddr == `REG_RDATA) rd_mux = {9'h000, rd_idx, rd_data};
        else if (araddr == `REG_PLAY_L) rd_mux = {12'h000, play.left};
        else if (araddr == `REG_PLAY_R) rd_mux = {12'h000, play.right};
        else if (araddr == `REG_REC_L) rd_mux = {12'h000, rec.left};
        else if (araddr == `REG_REC_R) rd_mux = {12'h000, rec.right};
        else if (araddr == `REG_SLOT12) rd_mux = {12'h000, slot12};
        else rd_hit = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {awready, wready, aw_got, w_got, bvalid} <= 5'h00;
            bresp <= `RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (ce) begin
            awready <= ~aw_got & ~aw_hs & ~bvalid;
            wready <= ~w_got & ~w_hs & ~bvalid;
            if (aw_hs) {aw_got, aw_addr_q} <= {1'b1, awaddr};
            if (w_hs) {w_got, w_data_q, w_strb_q} <= {1'b1, wdata, wstrb};
            if (do_wr) begin
                {aw_got, w_got, bvalid} <= 3'h1;
                bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid & bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {arready, rvalid} <= 2'h0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (ce) begin
            arready <= ~ar_hs & ~rvalid;
            if (ar_hs) begin
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid & rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers and the automatic power register read
    wire ready_rise = codec_ready & ~ready_q;
    wire auto_go = ready_rise & ~cmd_pend & ~wr_cmd;
    wire cmd_set = wr_cmd | auto_go;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run <= 1'b0;
            cmd <= '0;
            play <= '0;
        end else if (ce) begin
            if (wr_ctrl) run <= ctrl_new[`CTRL_RUN];
            if (wr_cmd) cmd <= cmd_new[23:0];
            else if (auto_go) cmd <= '{rd: 1'b1, idx: `PD_REG_IDX, data: 16'h0000}; // [RQ22]
            if (wr_pl) play.left <= pl_new[19:0];
            if (wr_pr) play.right <= pr_new[19:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link state: idle, cold reset, warm reset, running frames
    wire hold_start = ce & (next_state != state) &
                      ((next_state == ST_COLD) | (next_state == ST_WARM));
    hold_timer #(.CYCLES(`HOLD_CYC)) u_hold (
        .clk(aclk),
        .rst_n(aresetn),
        .ce(ce),
        .start(hold_start),
        .busy(hold_busy)
    );
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cold_go) next_state = ST_COLD;
                else if (warm_go) next_state = ST_WARM; // [RQ5]
                else if (run) next_state = ST_RUN;
            end
            ST_COLD, ST_WARM: begin
                if (!hold_busy) next_state = ST_IDLE;
            end
            ST_RUN: begin
                if (cold_go) next_state = ST_COLD;
                else if (!run && frame_cnt == 8'h00) next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            link_reset_n <= 1'b1;
        end else if (ce) begin
            state <= next_state;
            link_reset_n <= (state != ST_COLD); // [RQ4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outgoing frame
    wire play_go = play_pend & codec_ready; // [RQ7] [RQ21]
    wire wr_op = cmd_pend & ~cmd.rd;
    wire [15:0] tx_tag = {cmd_pend | play_go, cmd_pend, wr_op, play_go, play_go,
                          9'h000, `CODEC_ID}; // [RQ9] [RQ12]
    wire [19:0] tx_s1 = cmd_pend ? {cmd.rd, cmd.idx, 12'h000} : 20'h0_0000; // [RQ16]
    wire [19:0] tx_s2 = wr_op ? {cmd.data, 4'h0} : 20'h0_0000; // [RQ17]
    wire [19:0] tx_s3 = play_go ? play.left : 20'h0_0000; // [RQ18]
    wire [19:0] tx_s4 = play_go ? play.right : 20'h0_0000; // [RQ18]
    wire [255:0] tx_frame = {tx_tag, tx_s1, tx_s2, tx_s3, tx_s4, 160'h0}; // [RQ8] [RQ14]
    wire frame_open = bclk_rise & (state == ST_RUN) & (frame_cnt == 8'h00);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {link_sync, link_sdata_out, frames_live} <= 3'h0;
            frame_cnt <= 8'h00;
            tx_shift <= '0;
        end else if (ce) begin
            if (state == ST_WARM) begin
                link_sync <= 1'b1; // [RQ5]
            end else if (state != ST_RUN) begin
                {link_sync, link_sdata_out, frames_live} <= 3'h0;
                frame_cnt <= 8'h00;
            end else if (bclk_rise) begin
                frame_cnt <= frame_cnt + 8'h01; // [RQ2]
                link_sync <= (frame_cnt < `SYNC_HIGH_BITS); // [RQ10] [RQ13]
                if (frame_cnt == `SYNC_HIGH_BITS) frames_live <= 1'b1;
                if (frame_open) begin
                    tx_shift <= tx_frame;
                    link_sdata_out <= 1'b0;
                end else begin
                    link_sdata_out <= tx_shift[255]; // [RQ3]
                    tx_shift <= {tx_shift[254:0], 1'b0};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // incoming frame: sampled on falling edges, decoded as the last bit lands
    wire [255:0] rx_full = {rx_shift, din_s};
    wire [15:0] rx_tag = rx_full[255:240];
    wire [19:0] rx_s1 = slot_of(rx_full, 1);
    wire [19:0] rx_s2 = slot_of(rx_full, 2);
    wire frame_done = bclk_fall & (state == ST_RUN) & frames_live & (frame_cnt == 8'h01);
    wire rx_ok = frame_done & rx_tag[`TAG_VALID]; // [RQ20] [RQ21]
    wire rd_got = rx_ok & rx_tag[`TAG_S1] & rx_tag[`TAG_S2] & rd_wait; // [RQ28]
    wire cmd_sent = frame_open & cmd_pend;
    wire play_sent = frame_open & play_go;
    always_ff @(posedge aclk) begin
        if (!aresetn) rx_shift <= '0;
        else if (bclk_fall & (state == ST_RUN)) rx_shift <= rx_full[254:0]; // [RQ3] [RQ24]
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {cmd_pend, rd_wait, play_pend, rd_done} <= 4'h0;
        end else if (ce) begin
            cmd_pend <= cmd_set | (cmd_pend & ~cmd_sent);
            rd_wait <= (cmd_sent & cmd.rd) | (rd_wait & ~rd_got);
            play_pend <= wr_pr | (play_pend & ~play_sent);
            rd_done <= rd_got | (rd_done & ~rd_clr);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {codec_ready, ready_q} <= 2'h0;
            {rd_idx, rd_data} <= 23'h00_0000;
            rec <= '0;
            slot12 <= 20'h0_0000;
        end else if (ce) begin
            ready_q <= codec_ready;
            if ((state == ST_COLD) | (state == ST_WARM)) codec_ready <= 1'b0; // [RQ7]
            else if (frame_done) codec_ready <= rx_tag[`TAG_VALID]; // [RQ20]
            if (rd_got) begin
                rd_idx <= rx_s1[18:12];
                rd_data <= rx_s2[19:4];
            end
            if (rx_ok & rx_tag[`TAG_S3]) rec.left <= slot_of(rx_full, 3);
            if (rx_ok & rx_tag[`TAG_S4]) rec.right <= slot_of(rx_full, 4);
            if (rx_ok & rx_tag[`TAG_S12]) slot12 <= slot_of(rx_full, 12);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    localparam int HOLD_MIN = `HOLD_CYC;
    logic [7:0] rst_low;
    always_ff @(posedge aclk) begin
        if (!aresetn || link_reset_n) rst_low <= 8'h00;
        else if (ce && rst_low != 8'hFF) rst_low <= rst_low + 8'h01;
    end

    sequence s_frame_open;
        bclk_rise && state == ST_RUN && frame_cnt == 8'h00;
    endsequence
    property p_sync_start;
        s_frame_open |=> link_sync && !link_sdata_out;
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("sync did not open frame"); // [RQ13]
    property p_sync_len;
        link_sync && state == ST_RUN |-> frame_cnt >= 8'h01 && frame_cnt <= `SYNC_HIGH_BITS;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync high outside tag phase"); // [RQ10]
    property p_rise_only;
        $changed(link_sdata_out) && $past(state) == ST_RUN && state == ST_RUN
            |-> $past(bclk_rise);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("data moved off rising edge"); // [RQ3]
    property p_cold_len;
        $rose(link_reset_n) && $past(aresetn) |-> $past(rst_low) >= HOLD_MIN;
    endproperty
    a_cold_len: assert property (p_cold_len) else $error("cold reset too short"); // [RQ4]
    property p_warm;
        state == ST_WARM && ce |=> link_sync;
    endproperty
    a_warm: assert property (p_warm) else $error("sync low during warm reset"); // [RQ5]
    property p_play_ready;
        tx_tag[`TAG_S3] || tx_tag[`TAG_S4] |-> codec_ready;
    endproperty
    a_play_ready: assert property (p_play_ready) else $error("playback before ready"); // [RQ7]
    property p_read_zero;
        cmd_pend && cmd.rd |-> tx_s2 == 20'h0_0000 && !tx_tag[`TAG_S2];
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("read slot 2 not zero"); // [RQ17]
    property p_pd_read;
        ce && ready_rise && !cmd_pend && !wr_cmd
            |=> cmd_pend && cmd.rd && cmd.idx == `PD_REG_IDX;
    endproperty
    a_pd_read: assert property (p_pd_read) else $error("power register not read"); // [RQ22]
endmodule // ac_link_host

// File: rtl/ac_link_consts.svh
// constants for the ac-link host: register map, fields, timing
`ifndef AC_LINK_CONSTS_SVH
`define AC_LINK_CONSTS_SVH
// How it works
// RQ1 - codec halves its crystal to make bit clock
// RQ2 - host frames are bit clock divided by 256
// RQ3 - drive on rising, sample on falling edge
// RQ4 - cold reset: reset low at least 1 us
// RQ5 - warm reset: sync high 1 us, no clock
// RQ6 - write to register 0 resets registers only
// RQ7 - no playback before codec ready seen
// RQ8 - tag slot plus twelve 20-bit slots
// RQ9 - tag bit one marks slot valid
// RQ10 - sync high sixteen bit clocks per frame
// RQ11 - codec logic static, keeps registers when halted
// RQ12 - tag: frame valid, slot flags, codec id
// RQ13 - sync rise, then first tag bit next edge
// RQ14 - msb first, unused bits zero filled
// RQ15 - 64 even 16-bit registers, odd reserved
// RQ16 - slot 1: read flag, index, zero tail
// RQ17 - slot 2: write data, zero on read
// RQ18 - slots 3,4: playback left and right
// RQ19 - codec ignores outgoing slots 5 to 12
// RQ20 - incoming tag bit 15 is codec ready
// RQ21 - poll ready before trusting incoming tag flags
// RQ22 - after ready, read power register 0x26; the code skips this read if a command is pending or written as ready rises
// RQ23 - incoming slots: status, record, slot12 status
// RQ24 - codec drives ready bit after seeing sync
// RQ25 - incoming slot 1 echoes register index
// RQ26 - incoming slot 2 holds read data
// RQ27 - incoming slots 5 to 11 zero
// RQ28 - read answer returns in next frame

// register map, byte addresses
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_CMD 8'h08
`define REG_RDATA 8'h0C
`define REG_PLAY_L 8'h10
`define REG_PLAY_R 8'h14
`define REG_REC_L 8'h18
`define REG_REC_R 8'h1C
`define REG_SLOT12 8'h20
// control fields
`define CTRL_RUN 0
`define CTRL_COLD 1
`define CTRL_WARM 2
// command fields
`define CMD_RD 23
`define CMD_IDX_HI 22
`define CMD_IDX_LO 16
// tag bit positions
`define TAG_VALID 15
`define TAG_S1 14
`define TAG_S2 13
`define TAG_S3 12
`define TAG_S4 11
`define TAG_S12 3
`define CODEC_ID 2'h0
// fixed values
`define PD_REG_IDX 7'h26
`define SYNC_HIGH_BITS 8'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// timing
`define CLK_PERIOD_NS 20
`define RESET_HOLD_NS 1000
`define HOLD_CYC ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: rtl/ac_link_pkg.sv
// types shared by the ac-link host
package ac_link_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COLD = 2'b01,
        ST_WARM = 2'b10,
        ST_RUN = 2'b11
    } link_state_e;
    typedef struct packed {
        logic rd;
        logic [6:0] idx;
        logic [15:0] data;
    } cmd_s;
    typedef struct packed {
        logic [19:0] left;
        logic [19:0] right;
    } pcm_s;
endpackage

// File: rtl/bit_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module bit_sync #(
    parameter int WIDTH = 2
) (
    // clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // bit_sync

// File: rtl/hold_timer.sv
// holds busy high for a fixed number of cycles after start
`timescale 1ns/1ns
module hold_timer #(
    parameter int CYCLES = 50
) (
    // clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic start,
    output logic busy
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
            busy <= 1'b0;
        end else if (ce) begin
            if (start) begin
                cnt <= W'(CYCLES - 1);
                busy <= 1'b1;
            end else if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end else begin
                busy <= 1'b0;
            end
        end
    end
endmodule // hold_timer

// File: verification/codec_model.sv
// behavioural codec at the far end of the link
`timescale 1ns/1ns
module codec_model #(
    parameter logic [15:0] PD_DEF = 16'h000F,
    parameter logic [19:0] REC_L = 20'h1_2345,
    parameter logic [19:0] REC_R = 20'hA_BCDE,
    parameter logic [19:0] GPIO = 20'h0_0001
) (
    // link pins
    input wire logic reset_n,
    input wire logic sync,
    input wire logic sdo,
    output logic bit_clk,
    output logic sdi,
    // bench side
    input wire logic clk_on,
    output logic [19:0] play_l,
    output logic [19:0] play_r,
    output int errs
);
    logic xtal = 0;
    logic sync_q = 0;
    logic ready = 0;
    logic rd_pend = 0;
    logic [6:0] rd_idx = 0;
    logic [15:0] regs [128];
    logic [255:0] sh = 0;
    logic [255:0] in_fr = 0;
    logic [19:0] s [13];
    int ip = 256, pc = 1000, hi = 0, frames = 0;
    initial begin
        bit_clk = 0;
        sdi = 0;
        errs = 0;
        play_l = 0;
        play_r = 0;
        reg_init();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic reg_init();
        foreach (regs[i]) regs[i] = 16'h0000;
        regs[7'h26] = PD_DEF;
    endtask
    always #40 xtal = ~xtal;
    // bit clock halves the crystal; halted clock leaves state intact
    always @(posedge xtal) bit_clk <= (clk_on && reset_n) ? ~bit_clk : 1'b0;
    // a cold reset or a write to register 0 clears registers, sync alone never does
    always @(negedge reset_n) begin
        reg_init();
        {ready, frames, pc, ip, hi, sync_q} = {1'b0, 32'd0, 32'd1000, 32'd256, 32'd0, 1'b0};
    end
    // warm reset: sync held high while the bit clock is stopped restarts framing
    time ws = 0;
    always @(posedge sync) if (!clk_on) ws = $time;
    always @(negedge sync) begin
        if (!clk_on) begin
            if ($time - ws < 1000) errs++;
            {pc, ip, hi, sync_q} = {32'd1000, 32'd256, 32'd0, 1'b0};
        end
    end
    task automatic decode();
        logic [15:0] tag;
        tag = sh[255:240];
        for (int k = 1; k <= 12; k++) begin
            s[k] = sh[259 - 20 * k -: 20];
            if (!tag[15 - k] && s[k] != 0) errs++;
        end
        if (tag[14:3] != 0 && !tag[15]) errs++;
        if (tag[1:0] != 2'b00 || s[1][11:0] != 0) errs++;
        if ((tag[12] || tag[11]) && !ready) errs++;
        if (tag[12]) play_l = s[3];
        if (tag[11]) play_r = s[4];
        if (tag[14] && s[1][19]) begin
            if (s[2] != 0) errs++;
            rd_pend = 1;
            rd_idx = s[1][18:12];
        end else if (tag[14] && tag[13]) begin
            if (s[2][3:0] != 0) errs++;
            regs[s[1][18:12]] = s[2][19:4];
            if (s[1][18:12] == 7'h00) reg_init();
        end
        frames++;
        if (frames >= 2) ready = 1;
    endtask
    always @(negedge bit_clk) begin
        sh = {sh[254:0], sdo};
        pc++;
        if (sync) hi++;
        else if (sync_q) begin
            if (hi != 16) errs++;
            hi = 0;
        end
        if (sync && !sync_q) begin
            if (pc < 512 && pc != 256) errs++;
            if (pc < 512) decode();
            pc = 0;
            ip = 0;
            in_fr = {ready, rd_pend, rd_pend, 2'b11, 7'h00, 1'b1, 3'b000,
                rd_pend ? {1'b0, rd_idx, 12'h000} : 20'h0_0000,
                rd_pend ? {regs[rd_idx], 4'h0} : 20'h0_0000,
                REC_L, REC_R, 140'h0, GPIO};
            rd_pend = 0;
        end
        sync_q = sync;
    end
    always @(posedge bit_clk) begin
        sdi = (ip < 256) ? in_fr[255 - ip] : 1'b0;
        ip++;
    end
endmodule // codec_model

// File: verification/tb_top.sv
// self-checking bench for the ac-link host
`timescale 1ns/1ns
`include "ac_link_consts.svh"
module tb_top;
    import ac_link_pkg::*;
    localparam logic [15:0] PD_DEF = 16'h000F;
    localparam logic [19:0] REC_L = 20'h1_2345;
    localparam logic [19:0] REC_R = 20'hA_BCDE;
    localparam logic [19:0] GPIO = 20'h0_0001;
    logic aclk = 0, aresetn = 0, clk_on = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, bit_clk, sdi, sync, sdo, reset_n;
    logic [1:0] bresp, rresp;
    logic [19:0] play_l, play_r;
    int perr, err_total = 0, compares = 0;
    time t;
    always #10 aclk = ~aclk;
    ac_link_host dut (.aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .link_bit_clk(bit_clk),
        .link_sdata_in(sdi), .link_sync(sync), .link_sdata_out(sdo), .link_reset_n(reset_n));
    codec_model #(.PD_DEF(PD_DEF), .REC_L(REC_L), .REC_R(REC_R), .GPIO(GPIO)) codec (
        .reset_n, .sync, .sdo, .bit_clk, .sdi, .clk_on, .play_l, .play_r, .errs(perr));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ok(input logic c);
        chk({31'h0, c}, 32'h0000_0001);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= v;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        q = rdata;
        r = rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        rd(a, q, r);
        chk(q, exp);
        chk({30'h0, r}, {30'h0, er});
    endtask
    // status poll with a bounded number of reads
    task automatic poll(input logic [31:0] mask, input logic [31:0] val);
        logic [1:0] r;
        d = ~val;
        for (int i = 0; i < 4000 && (d & mask) !== val; i++) rd(`REG_STAT, d, r);
        chk(d & mask, val);
    endtask
    task automatic rdreg(input logic [6:0] idx, input logic [15:0] exp);
        poll(32'h0000_0002, 32'h0000_0000);
        wr(`REG_CMD, {8'h00, 1'b1, idx, 16'h0000}, `RESP_OKAY);
        poll(32'h0000_0004, 32'h0000_0004);
        rdc(`REG_RDATA, {9'h000, idx, exp}, `RESP_OKAY);
    endtask
    task automatic summarize();
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1500us;
        err_total++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({29'h0, sync, sdo, reset_n}, 32'h0000_0001);
        rdc(`REG_STAT, 32'h0000_0000, `RESP_OKAY);
        rdc(8'h24, 32'h0000_0000, `RESP_SLVERR);
        wr(8'h24, 32'hFFFF_FFFF, `RESP_SLVERR);
        wr(`REG_CTRL, 32'h0000_0002, `RESP_OKAY);
        wait (!reset_n);
        t = $time;
        wait (reset_n);
        ok($time - t >= 1000);
        wr(`REG_PLAY_L, 32'h000F_EDCB, `RESP_OKAY);
        wr(`REG_PLAY_R, 32'h0001_2340, `RESP_OKAY);
        wr(`REG_CTRL, 32'h0000_0001, `RESP_OKAY);
        poll(32'h0000_0001, 32'h0000_0001);
        poll(32'h0000_0004, 32'h0000_0004);
        rdc(`REG_RDATA, {9'h000, `PD_REG_IDX, PD_DEF}, `RESP_OKAY);
        wr(`REG_CMD, {8'h00, 1'b0, 7'h10, 16'hA5C3}, `RESP_OKAY);
        rdreg(7'h10, 16'hA5C3);
        chk({12'h000, play_l}, 32'h000F_EDCB);
        chk({12'h000, play_r}, 32'h0001_2340);
        rdc(`REG_REC_L, {12'h000, REC_L}, `RESP_OKAY);
        rdc(`REG_REC_R, {12'h000, REC_R}, `RESP_OKAY);
        rdc(`REG_SLOT12, {12'h000, GPIO}, `RESP_OKAY);
        wr(`REG_CTRL, 32'h0000_0000, `RESP_OKAY);
        poll(32'h0000_0030, 32'h0000_0000);
        clk_on <= 1'b0;
        wr(`REG_CTRL, 32'h0000_0004, `RESP_OKAY);
        wait (sync);
        t = $time;
        wait (!sync);
        ok($time - t >= 1000);
        clk_on <= 1'b1;
        wr(`REG_CTRL, 32'h0000_0001, `RESP_OKAY);
        poll(32'h0000_0001, 32'h0000_0001);
        poll(32'h0000_0004, 32'h0000_0004);
        rdc(`REG_RDATA, {9'h000, `PD_REG_IDX, PD_DEF}, `RESP_OKAY);
        rdreg(7'h10, 16'hA5C3);
        wr(`REG_CMD, {8'h00, 1'b0, 7'h00, 16'h1234}, `RESP_OKAY);
        rdreg(7'h10, 16'h0000);
        chk(perr, 32'h0000_0000);
        summarize();
    end
endmodule // tb_top
